// file: tick_timer.v
/*
 Periodic interval timer producing the operating-system tick request.
 Holds a 20-bit interval counter and a 12-bit elapsed-interval count,
 the counter stepping at master clock / 16 and the count once per interval, plus four software registers.
 Assumes a plain register port with read data one cycle after the read
 strobe, a synchronous debug-state input from the core, one clock.
*/
// Strobed register access was decided locally.
// Notes on behaviour
// - 20-bit counter at clock/16 step, 12-bit count steps once per wrap
// - Count up, wrap at limit, bump count
// - Limit sets flag; irq is flag and enable
// - New limit never resets the counters
// - Value read returns counts, clears count, flag
// - Snapshot read has no side effects
// - Enable clear at reset, applied at zero
// - Disabled counter finishes interval, then rests
// - Debug state freezes both counters
// - Interval lasts limit plus one ticks
// - Mode: limit 19:0, enables 24, 25
// - Values: count 31:20, counter 19:0
// - Status bit 0 shows reached flag
`timescale 1ns/10ps
`include "tick_timer_defs.vh"

module tick_timer (
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire [3:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   input  wire        debug_halt_i,
   output reg  [31:0] rdata_o,
   output reg         tick_irq_o
);

   reg  [19:0] interval_limit_q;
   reg         timer_enable_bit_q;
   reg         tick_irq_enable_q;
   reg  [19:0] interval_counter_q;
   reg  [19:0] interval_counter_d;
   reg  [11:0] elapsed_interval_count_q;
   reg  [11:0] elapsed_interval_count_d;
   reg         interval_reached_flag_q;
   reg         interval_reached_flag_d;
   reg  [31:0] rdata_d;
   wire        tick;
   wire        at_limit;
   wire        ack_read;
   wire [31:0] value_word;

   // Prescaler, frozen in debug state
   tick_divider u_div (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .halt_i  (debug_halt_i),
      .tick_o  (tick)
   );

   assign at_limit   = (interval_counter_q == interval_limit_q);
   assign ack_read   = rd_i && (addr_i == `OFS_INTERVAL_VALUE_ACK);
   assign value_word = {elapsed_interval_count_q,
                        interval_counter_q};

   // Mode register writes; counters untouched by them
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interval_limit_q   <= `LIMIT_RESET;
         timer_enable_bit_q <= 1'b0;
         tick_irq_enable_q  <= 1'b0;
      end else if (wr_i && (addr_i == `OFS_INTERVAL_MODE)) begin
         interval_limit_q   <= wdata_i[`LIMIT_MSB:`LIMIT_LSB];
         timer_enable_bit_q <= wdata_i[`TIMER_ENABLE_BIT];
         tick_irq_enable_q  <= wdata_i[`TICK_IRQ_ENABLE_BIT];
      end
   end

   // Counter and flag next state
   always @* begin
      interval_counter_d       = interval_counter_q;
      elapsed_interval_count_d = elapsed_interval_count_q;
      interval_reached_flag_d  = interval_reached_flag_q;
      // Acknowledge first so a same-cycle wrap still wins
      if (ack_read) begin
         elapsed_interval_count_d = 12'h000;
         interval_reached_flag_d  = 1'b0;
      end
      // Enable only matters at zero; a started interval always ends
      if (tick && !debug_halt_i) begin
         if (timer_enable_bit_q ||
             (interval_counter_q != 20'h00000)) begin
            if (at_limit) begin
               interval_counter_d = 20'h00000;
               // Period is limit plus one ticks
               elapsed_interval_count_d =
                  elapsed_interval_count_d + 12'h001;
               interval_reached_flag_d  = 1'b1;
            end else begin
               interval_counter_d =
                  interval_counter_q + 20'h00001;
            end
         end
      end
   end

   // Counter registers
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interval_counter_q       <= 20'h00000;
         elapsed_interval_count_q <= 12'h000;
         interval_reached_flag_q  <= 1'b0;
      end else begin
         interval_counter_q       <= interval_counter_d;
         elapsed_interval_count_q <= elapsed_interval_count_d;
         interval_reached_flag_q  <= interval_reached_flag_d;
      end
   end

   // Read mux
   always @* begin
      rdata_d = 32'h00000000;
      if (!rd_i) begin
         rdata_d = 32'h00000000;
      end else if (addr_i == `OFS_INTERVAL_MODE) begin
         rdata_d[`LIMIT_MSB:`LIMIT_LSB] = interval_limit_q;
         rdata_d[`TIMER_ENABLE_BIT]     = timer_enable_bit_q;
         rdata_d[`TICK_IRQ_ENABLE_BIT]  = tick_irq_enable_q;
      end else if (addr_i == `OFS_INTERVAL_STATUS) begin
         rdata_d[`REACHED_BIT] = interval_reached_flag_q;
      end else if (addr_i == `OFS_INTERVAL_VALUE_ACK) begin
         rdata_d = value_word;
      end else if (addr_i == `OFS_INTERVAL_SNAPSHOT) begin
         rdata_d = value_word;
      end else begin
         rdata_d = 32'h00000000;                           // Unmapped
      end
   end

   // Registered outputs
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o    <= 32'h00000000;
         tick_irq_o <= 1'b0;
      end else begin
         rdata_o    <= rdata_d;
         tick_irq_o <= interval_reached_flag_d &&
                       tick_irq_enable_q;
      end
   end

endmodule

// file: tick_timer_defs.vh
/*
 Constants for the periodic interval timer: register offsets, field
 positions, reset values and the clock divider count.
 Assumes inclusion by bare name from the design files.
*/
`ifndef TICK_TIMER_DEFS_VH
`define TICK_TIMER_DEFS_VH

// Register byte offsets
`define OFS_INTERVAL_MODE      4'h0
`define OFS_INTERVAL_STATUS    4'h4
`define OFS_INTERVAL_VALUE_ACK 4'h8
`define OFS_INTERVAL_SNAPSHOT  4'hc

// Mode register fields
`define LIMIT_MSB              19
`define LIMIT_LSB              0
`define TIMER_ENABLE_BIT       24
`define TICK_IRQ_ENABLE_BIT    25

// Value register fields
`define COUNT_MSB              31
`define COUNT_LSB              20

// Status register field
`define REACHED_BIT            0

// Reset values
`define MODE_RESET             32'h000fffff
`define LIMIT_RESET            20'hfffff

// Divider: one tick every 16 master clocks
`define DIV_RATIO              16
`define DIV_LAST               4'hf

`endif

// file: tick_divider.v
/*
 Divide-by-16 tick generator for the interval counters.
 Assumes a single clock and an active-low asynchronous reset; the
 halt input freezes the prescaler together with the counters.
*/
`timescale 1ns/10ps
`include "tick_timer_defs.vh"

module tick_divider (
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire        halt_i,
   output reg         tick_o
);

   reg  [3:0] div_q;

   // Free-running prescaler, paused while halted; a pending tick
   // is held through the halt so no interval step is lost
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q  <= 4'h0;
         tick_o <= 1'b0;
      end else if (halt_i) begin
         tick_o <= tick_o;
      end else begin
         div_q  <= div_q + 4'h1;
         tick_o <= (div_q == `DIV_LAST);
      end
   end

endmodule

// file: tick_timer_checker.sv
/* Port checks for tick_timer.
   Assumes binding to tick_timer: one clock, reset active low. */
`timescale 1ns/10ps
module tick_timer_checker (
   input wire        mclk_i,
   input wire        rst_n_i,
   input wire [3:0]  addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire        debug_halt_i,
   input wire [31:0] rdata_o,
   input wire        tick_irq_o
);
   reg [31:0] mode_q;
   // Shadow of the mode register, reserved bits dropped
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         mode_q <= 32'h000fffff;
      else if (wr_i && addr_i == 4'h0)
         mode_q <= wdata_i & 32'h030fffff;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Read of one place while the core is halted
   sequence hrd(a);
      rd_i && addr_i == a && debug_halt_i;
   endsequence
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("data outside read");
   a_mode_back: assert property ($past(rd_i && addr_i == 4'h0) |->
      rdata_o == $past(mode_q)) else $error("mode readback");
   a_stat_resv: assert property ($past(rd_i && addr_i == 4'h4) |->
      rdata_o[31:1] == 31'h0) else $error("status reserved");
   a_unmapped_zero: assert property ($past(rd_i && addr_i[1:0] != 2'h0)
      |-> rdata_o == 32'h0) else $error("unmapped read");
   a_irq_masked: assert property (tick_irq_o |-> $past(mode_q[25]))
      else $error("irq while masked");
   a_halt_frozen: assert property (hrd(4'hc) ##1 debug_halt_i ##1 hrd(4'hc)
      |=> rdata_o == $past(rdata_o, 2)) else $error("moved in halt");
   a_ack_count: assert property (hrd(4'h8) ##1 debug_halt_i ##1 hrd(4'hc)
      |=> rdata_o[31:20] == 12'h0) else $error("count kept");
   a_ack_irq: assert property (hrd(4'h8) ##1 debug_halt_i |=> !tick_irq_o)
      else $error("irq kept");
   c_irq: cover property ($rose(tick_irq_o));
   c_ack: cover property (rd_i && addr_i == 4'h8 && tick_irq_o);
   c_halt: cover property (hrd(4'hc));
endmodule

// file: tick_timer_tb_top.sv
/* Bench for tick_timer over its register port.
   Assumes the checker file is compiled first. */
`timescale 1ns/10ps
module tick_timer_tb_top;
   reg         mclk_i = 1'b0;
   reg         rst_n_i = 1'b0;
   reg  [3:0]  addr_i = 4'h0;
   reg  [31:0] wdata_i = 32'h0;
   reg         wr_i = 1'b0;
   reg         rd_i = 1'b0;
   reg         debug_halt_i = 1'b0;
   wire [31:0] rdata_o;
   wire        tick_irq_o;
   integer     miscompares = 0;
   integer     samples_checked = 0;
   integer     i;
   reg  [31:0] s1;
   reg  [31:0] s2;
   tick_timer i_tick_timer (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .debug_halt_i, .rdata_o, .tick_irq_o);
   // 10 MHz clock
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   task chk(input [31:0] v, input [31:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (v !== e) begin
            miscompares = miscompares + 1;
            $display("FAIL %0t got %h want %h", $time, v, e);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge mclk_i);
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge mclk_i);
         wr_i <= 1'b0;
      end
   endtask
   // Data sampled mid-cycle after the strobe
   task rd(input [3:0] a, output [31:0] v);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge mclk_i);
         rd_i <= 1'b0;
         @(negedge mclk_i);
         v = rdata_o;
      end
   endtask
   task rdc(input [3:0] a, input [31:0] e);
      begin
         rd(a, s2);
         chk(s2, e);
      end
   endtask
   // Snapshots n cycles apart differ by dc intervals
   task span(input integer n, input [11:0] dc);
      begin
         rd(4'hc, s1);
         cyc(n - 2);
         rd(4'hc, s2);
         chk(s2 - s1, {dc, 20'h0});
      end
   endtask
   task results;
      begin
         $display("checks %0d bad %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Hang guard
   initial begin
      cyc(90000);
      miscompares = miscompares + 1;
      results;
   end
   initial begin
      cyc(12);
      rst_n_i <= 1'b1;
      cyc(100);
      rdc(4'h0, 32'h000fffff);
      rdc(4'h4, 32'h0);
      rdc(4'h8, 32'h0);
      rdc(4'hc, 32'h0);
      rdc(4'h2, 32'h0);
      $display("test 1 done");
      wr(4'h0, 32'hff000003);
      rdc(4'h0, 32'h03000003);
      for (i = 0; i < 200 && tick_irq_o !== 1'b1; i = i + 1)
         @(posedge mclk_i);
      rdc(4'h4, 32'h1);
      rd(4'hc, s1);
      chk({31'h0, tick_irq_o}, 32'h1);
      rd(4'h8, s1);
      chk(s1 >> 20, 32'h1);
      rd(4'hc, s1);
      chk(s1 >> 20, 32'h0);
      chk({31'h0, tick_irq_o}, 32'h0);
      wr(4'h0, 32'h01000003);
      cyc(100);
      chk({31'h0, tick_irq_o}, 32'h0);
      rdc(4'h4, 32'h1);
      wr(4'h0, 32'h03000003);
      cyc(2);
      chk({31'h0, tick_irq_o}, 32'h1);
      span(64, 12'h1);
      $display("test 2 done");
      @(posedge mclk_i);
      debug_halt_i <= 1'b1;
      rd(4'hc, s1);
      rdc(4'hc, s1);
      rd(4'h8, s1);
      rdc(4'hc, s1 & 32'hfffff);
      wr(4'h0, 32'h0300000f);
      cyc(50);
      rdc(4'hc, s1 & 32'hfffff);
      @(posedge mclk_i);
      debug_halt_i <= 1'b0;
      wr(4'h0, 32'h0200000f);
      cyc(400);
      rd(4'hc, s1);
      chk(s1 & 32'hfffff, 32'h0);
      span(100, 12'h0);
      wr(4'h0, 32'h03000000);
      span(65552, 12'h1);
      $display("test 3 done");
      results;
   end
endmodule
bind tick_timer tick_timer_checker i_tick_timer_checker (.mclk_i, .rst_n_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .debug_halt_i, .rdata_o, .tick_irq_o);
